//--- inc/swc_pkg.sv
`default_nettype none
package swc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] SWC_IDX_WAKE_CTRL  = 6'h0C;
  localparam logic [5:0] SWC_IDX_WAKE_LEVEL = 6'h0D;
  localparam logic [5:0] SWC_IDX_WDT_MODE   = 6'h0F;
  localparam logic [5:0] SWC_IDX_STATUS     = 6'h10;
  localparam logic [5:0] SWC_IDX_MASK       = 6'h11;
  localparam logic [5:0] SWC_IDX_STATE      = 6'h12;

  // Fields of stop_wake_ctrl.
  localparam int SWC_DIV16_BIT = 0;
  localparam int SWC_SRC_LSB   = 2;
  localparam int SWC_DELAY_BIT = 5;
  localparam logic [7:0] SWC_WAKE_CTRL_RST = 8'h00;
  localparam logic [7:0] SWC_WAKE_CTRL_RD  = 8'h3D;

  // Fields of stop_wake_level_ctrl.
  localparam int SWC_LEVEL_BIT = 6;
  localparam logic SWC_LEVEL_RST = 1'b0;

  // Fields of watchdog_mode.
  localparam int SWC_WDT_SEL_LSB  = 0;
  localparam int SWC_WDT_HALT_BIT = 2;
  localparam logic [2:0] SWC_WDT_MODE_RST = 3'h4;

  // Event bits shared by status and mask.
  localparam int SWC_EV_WAKE  = 0;
  localparam int SWC_EV_WDT   = 1;
  localparam int SWC_EV_READY = 2;
  localparam int SWC_EV_W     = 3;
  localparam logic [2:0] SWC_MASK_RST = 3'h0;

  // Timing at a 40 ns clock.
  localparam int unsigned SWC_CLK_NS   = 40;
  localparam int unsigned SWC_T_POR_US = 5000;
  localparam int unsigned SWC_T_WDT0_US = 5000;
  localparam int unsigned SWC_T_WDT1_US = 10000;
  localparam int unsigned SWC_T_WDT2_US = 20000;
  localparam int unsigned SWC_T_WDT3_US = 80000;
  localparam int unsigned SWC_POR_CYC  = (SWC_T_POR_US * 1000 + SWC_CLK_NS - 1) / SWC_CLK_NS;
  localparam int unsigned SWC_WDT_CYC0 = (SWC_T_WDT0_US * 1000 + SWC_CLK_NS - 1) / SWC_CLK_NS;
  localparam int unsigned SWC_WDT_CYC1 = (SWC_T_WDT1_US * 1000 + SWC_CLK_NS - 1) / SWC_CLK_NS;
  localparam int unsigned SWC_WDT_CYC2 = (SWC_T_WDT2_US * 1000 + SWC_CLK_NS - 1) / SWC_CLK_NS;
  localparam int unsigned SWC_WDT_CYC3 = (SWC_T_WDT3_US * 1000 + SWC_CLK_NS - 1) / SWC_CLK_NS;
  localparam int unsigned SWC_PRESCALE = 16;

  // Wake source code k selects input map[3k+2:3k]; identity by default.
  localparam logic [23:0] SWC_WAKE_MAP_DEF = 24'hFAC688;

  typedef enum logic [1:0] {
    SWC_ST_RUN,
    SWC_ST_STOP,
    SWC_ST_DELAY
  } swc_state_t;

endpackage
`default_nettype wire

//--- inc/swc_wdt_if.sv
`default_nettype none
interface swc_wdt_if;
  logic       kick;
  logic       run;
  logic       halt;
  logic       halt_run;
  logic [1:0] sel;
  logic       expire;

  modport ctrl (output kick, run, halt, halt_run, sel, input expire);
  modport wdt  (input kick, run, halt, halt_run, sel, output expire);
endinterface
`default_nettype wire

//--- src/swc_prescaler.sv
`default_nettype none
module swc_prescaler
  import swc_pkg::*;
#(
  parameter int unsigned DIV = SWC_PRESCALE
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  output var  logic tick_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_d;

  always_comb begin
    cnt_d  = (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
    tick_d = (cnt_d == 8'(DIV - 1));
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end

  AST_PRE_PERIOD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    tick_o |=> !tick_o [*2]) else $error("Prescaler tick repeated too soon.");
endmodule
`default_nettype wire

//--- src/swc_wdt.sv
`default_nettype none
module swc_wdt
  import swc_pkg::*;
#(
  parameter int unsigned WDT_CYC0 = SWC_WDT_CYC0,
  parameter int unsigned WDT_CYC1 = SWC_WDT_CYC1,
  parameter int unsigned WDT_CYC2 = SWC_WDT_CYC2,
  parameter int unsigned WDT_CYC3 = SWC_WDT_CYC3
) (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  swc_wdt_if.wdt    wif
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic [31:0] lim;
  logic        exp_q;
  logic        exp_d;
  logic        active;

  always_comb begin
    case (wif.sel)
      2'h0:    lim = 32'(WDT_CYC0);
      2'h1:    lim = 32'(WDT_CYC1);
      2'h2:    lim = 32'(WDT_CYC2);
      default: lim = 32'(WDT_CYC3);
    endcase
    // Counting pauses in HALT unless the halt-run bit is set.
    active = wif.run && (!wif.halt || wif.halt_run);
    cnt_d  = cnt_q;
    exp_d  = 1'b0;
    if (wif.kick) begin
      cnt_d = 32'h0;
    end else if (active) begin
      if (cnt_q >= lim - 32'h1) begin
        cnt_d = 32'h0;
        exp_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 32'h0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end

  assign wif.expire = exp_q;

  AST_WDT_HALT_FREEZE: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wif.halt && !wif.halt_run && !wif.kick) |=> $stable(cnt_q)) else $error("Watchdog counted in HALT.");
  AST_WDT_TIMEOUT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (active && !wif.kick && cnt_q == lim - 32'h1) |=> exp_q && cnt_q == 32'h0) else $error("Timeout missed.");
endmodule
`default_nettype wire

//--- src/swc_stop_recovery_watchdog_ctrl.sv
// How it works
// - With the delay bit set, execution stays held after a STOP wake-up for the power-on reset time.
// - With the delay bit clear, execution resumes on the cycle after the wake-up.
// - The divide bit slows the system clock enable, and the timer clock enable only in HALT, to one edge in sixteen.
// - Every STOP wake-up clears the divide bit.
// - The three-bit source field picks the input that wakes the device from STOP.
// - The write-only level bit picks the active wake level, low after reset.
// - The two watchdog select bits give timeouts of 5, 10, 20 or 80 ms.
// - The watchdog halt bit keeps it counting in HALT when one, the default, and stops it when zero.
// - The watchdog mode register resets to its defaults but keeps its contents across a wake-up.
// - The watchdog mode register is write-only and reads as zero.
// - The wake input's port direction is forced back to input on wake-up.
`default_nettype none
module swc_stop_recovery_watchdog_ctrl
  import swc_pkg::*;
#(
  parameter int unsigned POR_CYC  = SWC_POR_CYC,
  parameter int unsigned WDT_CYC0 = SWC_WDT_CYC0,
  parameter int unsigned WDT_CYC1 = SWC_WDT_CYC1,
  parameter int unsigned WDT_CYC2 = SWC_WDT_CYC2,
  parameter int unsigned WDT_CYC3 = SWC_WDT_CYC3,
  parameter logic [23:0] WAKE_MAP = SWC_WAKE_MAP_DEF
) (
  // Clock and reset.
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  output var  logic [31:0] hrdata_o,
  // Core side.
  input  wire logic        stop_req_i,
  input  wire logic        halt_i,
  input  wire logic        wdt_kick_i,
  input  wire logic [7:0]  wake_in_i,
  output var  logic        exec_en_o,
  output var  logic        sys_clk_en_o,
  output var  logic        timer_clk_en_o,
  output var  logic [7:0]  wake_port_in_o,
  output logic             wdt_rst_o,
  output var  logic        irq_o
);
  swc_wdt_if wif ();

  logic             pre_tick;
  swc_state_t       st_q;
  swc_state_t       st_d;
  logic [31:0]      dly_q;
  logic [31:0]      dly_d;
  logic [7:0]       swc_q;
  logic [7:0]       swc_d;
  logic             lvl_q;
  logic             lvl_d;
  logic [2:0]       wdm_q;
  logic [2:0]       wdm_d;
  logic [2:0]       sts_q;
  logic [2:0]       sts_d;
  logic [2:0]       msk_q;
  logic [2:0]       msk_d;
  logic             wr_q;
  logic             wr_d;
  logic [5:0]       widx_q;
  logic [5:0]       widx_d;
  logic [31:0]      rdata_d;
  logic             acc;
  logic             rd_acc;
  logic [5:0]       aidx;
  logic [2:0]       src_code;
  logic [2:0]       src_line;
  logic             wake_hit;
  logic             ready_evt;
  logic [2:0]       sts_set;
  logic [2:0]       sts_clr;
  logic             exec_d;
  logic             sys_en_d;
  logic             tmr_en_d;
  logic [7:0]       port_d;

  swc_prescaler #(
    .DIV (SWC_PRESCALE)
  ) u_pre (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .tick_o  (pre_tick)
  );

  swc_wdt #(
    .WDT_CYC0 (WDT_CYC0),
    .WDT_CYC1 (WDT_CYC1),
    .WDT_CYC2 (WDT_CYC2),
    .WDT_CYC3 (WDT_CYC3)
  ) u_wdt (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .wif     (wif)
  );

  assign wif.kick     = wdt_kick_i;
  assign wif.run      = (st_q != SWC_ST_STOP);
  assign wif.halt     = halt_i;
  assign wif.halt_run = wdm_q[SWC_WDT_HALT_BIT];
  assign wif.sel      = wdm_q[SWC_WDT_SEL_LSB +: 2];
  assign wdt_rst_o    = wif.expire;

  // Bus address phase and wake source decode.
  always_comb begin
    acc      = hsel_i && hready_i && htrans_i[1];
    rd_acc   = acc && !hwrite_i;
    aidx     = haddr_i[7:2];
    src_code = swc_q[SWC_SRC_LSB +: 3];
    src_line = WAKE_MAP[3 * int'(src_code) +: 3];
    wake_hit = (st_q == SWC_ST_STOP) && (wake_in_i[src_line] == lvl_q);
  end

  // Recovery sequencer.
  always_comb begin
    st_d      = st_q;
    dly_d     = dly_q;
    ready_evt = 1'b0;
    case (st_q)
      SWC_ST_RUN: begin
        if (stop_req_i) begin
          st_d = SWC_ST_STOP;
        end
      end
      SWC_ST_STOP: begin
        if (wake_hit) begin
          dly_d = 32'h0;
          if (swc_q[SWC_DELAY_BIT]) begin
            st_d = SWC_ST_DELAY;
          end else begin
            st_d      = SWC_ST_RUN;
            ready_evt = 1'b1;
          end
        end
      end
      SWC_ST_DELAY: begin
        if (dly_q >= 32'(POR_CYC) - 32'h1) begin
          st_d      = SWC_ST_RUN;
          ready_evt = 1'b1;
        end else begin
          dly_d = dly_q + 32'h1;
        end
      end
      default: begin
        st_d = SWC_ST_RUN;
      end
    endcase
    exec_d   = (st_d == SWC_ST_RUN);
    sys_en_d = !swc_d[SWC_DIV16_BIT] || pre_tick;
    tmr_en_d = !(swc_d[SWC_DIV16_BIT] && halt_i) || pre_tick;
    port_d   = wake_hit ? (8'h01 << src_line) : 8'h00;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q           <= SWC_ST_RUN;
      dly_q          <= 32'h0;
      exec_en_o      <= 1'b1;
      sys_clk_en_o   <= 1'b1;
      timer_clk_en_o <= 1'b1;
      wake_port_in_o <= 8'h00;
    end else begin
      st_q           <= st_d;
      dly_q          <= dly_d;
      exec_en_o      <= exec_d;
      sys_clk_en_o   <= sys_en_d;
      timer_clk_en_o <= tmr_en_d;
      wake_port_in_o <= port_d;
    end
  end

  // Registers, bus data phase and interrupt.
  always_comb begin
    wr_d   = acc && hwrite_i;
    widx_d = aidx;
    swc_d  = swc_q;
    lvl_d  = lvl_q;
    wdm_d  = wdm_q;
    msk_d  = msk_q;
    if (wr_q) begin
      case (widx_q)
        SWC_IDX_WAKE_CTRL:  swc_d = hwdata_i[7:0];
        SWC_IDX_WAKE_LEVEL: lvl_d = hwdata_i[SWC_LEVEL_BIT];
        SWC_IDX_WDT_MODE:   wdm_d = hwdata_i[2:0];
        SWC_IDX_MASK:       msk_d = hwdata_i[2:0];
        default:            swc_d = swc_q;
      endcase
    end
    // A wake-up wins over a same-cycle write of the divide bit; watchdog mode is left alone.
    if (wake_hit) begin
      swc_d[SWC_DIV16_BIT] = 1'b0;
    end
    sts_set               = 3'h0;
    sts_set[SWC_EV_WAKE]  = wake_hit;
    sts_set[SWC_EV_WDT]   = wif.expire;
    sts_set[SWC_EV_READY] = ready_evt;
    sts_clr = (rd_acc && aidx == SWC_IDX_STATUS) ? 3'h7 : 3'h0;
    sts_d   = (sts_q & ~sts_clr) | sts_set;
    case (aidx)
      SWC_IDX_WAKE_CTRL: rdata_d = {24'h0, swc_q & SWC_WAKE_CTRL_RD};
      SWC_IDX_STATUS:    rdata_d = {29'h0, sts_q};
      SWC_IDX_MASK:      rdata_d = {29'h0, msk_q};
      SWC_IDX_STATE:     rdata_d = {29'h0, exec_en_o, st_q == SWC_ST_DELAY, st_q == SWC_ST_STOP};
      default:           rdata_d = 32'h0;
    endcase
    if (!rd_acc) begin
      rdata_d = hrdata_o;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q        <= 1'b0;
      widx_q      <= 6'h00;
      swc_q       <= SWC_WAKE_CTRL_RST;
      lvl_q       <= SWC_LEVEL_RST;
      wdm_q       <= SWC_WDT_MODE_RST;
      sts_q       <= 3'h0;
      msk_q       <= SWC_MASK_RST;
      hrdata_o    <= 32'h0;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      wr_q        <= wr_d;
      widx_q      <= widx_d;
      swc_q       <= swc_d;
      lvl_q       <= lvl_d;
      wdm_q       <= wdm_d;
      sts_q       <= sts_d;
      msk_q       <= msk_d;
      hrdata_o    <= rdata_d;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      irq_o       <= |(sts_d & msk_d);
    end
  end

  AST_DELAY_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wake_hit && swc_q[SWC_DELAY_BIT]) |=> !exec_en_o [*8]) else $error("Execution resumed during delay.");
  AST_NO_DELAY: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wake_hit && !swc_q[SWC_DELAY_BIT]) |=> exec_en_o) else $error("Resume without delay was late.");
  AST_DIV_SLOW: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (swc_d[SWC_DIV16_BIT] && !pre_tick) |=> !sys_clk_en_o) else $error("System clock not divided.");
  AST_DIV_CLEAR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wake_hit |=> !swc_q[SWC_DIV16_BIT] ##1 sys_clk_en_o) else $error("Divide bit kept after wake.");
  AST_WRONG_LEVEL: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st_q == SWC_ST_STOP && wake_in_i[src_line] != lvl_q) |=> st_q == SWC_ST_STOP) else $error("Woke on wrong level.");
  AST_WDM_KEEP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (wake_hit && !wr_q) |=> $stable(wdm_q)) else $error("Watchdog mode changed on wake.");
  AST_WDM_READ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (rd_acc && aidx == SWC_IDX_WDT_MODE) |=> hrdata_o == 32'h0) else $error("Watchdog mode readable.");
  AST_PORT_DIR: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wake_hit |=> wake_port_in_o == (8'h01 << $past(src_line)) ##1 wake_port_in_o == 8'h00)
    else $error("Port direction pulse wrong.");
  AST_IRQ: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (|(sts_q & msk_q)) |-> irq_o) else $error("Interrupt missing.");

  // Clock enables follow the divide bit, a wake-up is logged and leaves STOP, and STOP holds execution and the watchdog.
  AST_TMR_DIV: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (swc_d[SWC_DIV16_BIT] && halt_i && !pre_tick) |=> !timer_clk_en_o) else $error("Timer not divided.");
  AST_UNDIV: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !swc_d[SWC_DIV16_BIT] |=> sys_clk_en_o && timer_clk_en_o) else $error("Clock divided with bit clear.");
  AST_WAKE_STS: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    wake_hit |=> sts_q[SWC_EV_WAKE] && st_q != SWC_ST_STOP) else $error("Wake-up not recorded.");
  AST_STOP_HOLD: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st_q == SWC_ST_STOP) |-> !exec_en_o) else $error("Execution ran in STOP.");
  AST_WDT_STOP: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (st_q == SWC_ST_STOP) |-> !wif.run) else $error("Watchdog ran in STOP.");
endmodule
`default_nettype wire

//--- dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import swc_pkg::*;

  localparam int unsigned POR = 20;
  localparam int unsigned CYC[4] = '{10, 20, 40, 80};

  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [2:0]  hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0;
  wire logic   hready_i;
  logic        hreadyout_o;
  logic        hresp_o;
  logic [31:0] hrdata_o;
  logic        stop_req_i = 1'b0;
  logic        halt_i = 1'b0;
  logic        wdt_kick_i = 1'b0;
  logic [7:0]  wake_in_i = 8'hFF;
  logic        exec_en_o;
  logic        sys_clk_en_o;
  logic        timer_clk_en_o;
  logic [7:0]  wake_port_in_o;
  logic        wdt_rst_o;
  logic        irq_o;
  int          n_errors = 0;
  int          num_checks = 0;
  int          n;
  logic [7:0]  port;
  logic [31:0] v;

  assign hready_i = hreadyout_o;
  always #20 clock_i = ~clock_i;

  swc_stop_recovery_watchdog_ctrl #(
    .POR_CYC (POR),
    .WDT_CYC0(10),
    .WDT_CYC1(20),
    .WDT_CYC2(40),
    .WDT_CYC3(80)
  ) swc_stop_recovery_watchdog_ctrl_inst (
    .clock_i, .rst_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i,
    .hreadyout_o, .hresp_o, .hrdata_o, .stop_req_i, .halt_i, .wdt_kick_i, .wake_in_i, .exec_en_o,
    .sys_clk_en_o, .timer_clk_en_o, .wake_port_in_o, .wdt_rst_o, .irq_o
  );

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One single AHB-Lite transfer; read data is taken at the edge that ends the data phase.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock_i);
    hsel_i <= 1'b1;
    haddr_i <= {24'h0, a};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    do @(posedge clock_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
    chk("hresp", 1'b0, hresp_o);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(nm, e, x & m);
  endtask

  task automatic cnt(ref logic s, output int c);
    c = 0;
    repeat (64) begin
      @(negedge clock_i);
      c += int'(s === 1'b1);
    end
  endtask

  task automatic wdt_gap(output int c);
    int i;
    i = 0;
    do begin @(negedge clock_i); i++; end while (wdt_rst_o !== 1'b1 && i < 300);
    c = 0;
    do begin @(negedge clock_i); c++; end while (wdt_rst_o !== 1'b1 && c < 300);
  endtask

  // Enter STOP, show a non-selected line first, then the selected one.
  task automatic stop_wake(input int k, input logic lvl, output int c, output logic [7:0] p);
    @(posedge clock_i);
    stop_req_i <= 1'b1;
    @(posedge clock_i);
    stop_req_i <= 1'b0;
    wake_in_i <= {8{~lvl}} ^ (8'h01 << ((k + 1) % 8));
    repeat (4) @(negedge clock_i);
    chk("exec_held", 1'b0, exec_en_o);
    @(posedge clock_i);
    wake_in_i[k] <= lvl;
    c = 0;
    p = 8'h00;
    do begin @(negedge clock_i); c++; p |= wake_port_in_o; end while (exec_en_o !== 1'b1 && c < 200);
    @(posedge clock_i);
    wake_in_i <= {8{~lvl}};
  endtask

  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    chk("exec_rst", 1'b1, exec_en_o);
    halt_i <= 1'b1;
    wdt_gap(n);
    chk("wdt_default", 10, n);
    halt_i <= 1'b0;
    rd("ctrl_rst", 8'h30, 32'hFFFF_FFFF, 32'h0);
    rd("level_rst", 8'h34, 32'hFFFF_FFFF, 32'h0);
    rd("mask_rst", 8'h44, 32'hFFFF_FFFF, 32'h0);
    rd("state_rst", 8'h48, 32'hFFFF_FFFF, 32'h4);
    wr(8'h30, 32'hFF);
    rd("ctrl_rw", 8'h30, 32'hFFFF_FFFF, 32'h3D);
    wr(8'h34, 32'h40);
    rd("level_wo", 8'h34, 32'hFFFF_FFFF, 32'h0);
    wr(8'h3C, 32'h7);
    rd("wdt_wo", 8'h3C, 32'hFFFF_FFFF, 32'h0);
    wr(8'h80, 32'hFF);
    rd("unmapped", 8'h80, 32'hFFFF_FFFF, 32'h0);
    wr(8'h34, 32'h0);
    wr(8'h30, 32'h01);
    cnt(sys_clk_en_o, n);
    chk("sys_div", 4, n);
    cnt(timer_clk_en_o, n);
    chk("timer_run", 64, n);
    halt_i <= 1'b1;
    cnt(timer_clk_en_o, n);
    chk("timer_halt", 4, n);
    halt_i <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      wr(8'h30, 32'((k << 2) | 1));
      stop_wake(k, 1'b0, n, port);
      chk("wake_fast", 2, n);
      chk("wake_port", 8'h01 << k, port);
      chk("irq_masked", 1'b0, irq_o);
      rd("div_clr", 8'h30, 32'hFFFF_FFFF, 32'(k << 2));
      rd("status", 8'h40, 32'h5, 32'h5);
    end
    wr(8'h44, 32'h1);
    wr(8'h34, 32'h40);
    wr(8'h30, 32'h20);
    wake_in_i <= 8'h00;
    stop_wake(0, 1'b1, n, port);
    chk("wake_delay", 2 + POR, n);
    repeat (2) @(negedge clock_i);
    chk("irq_set", 1'b1, irq_o);
    rd("status_wake", 8'h40, 32'h5, 32'h5);
    rd("status_clr", 8'h40, 32'h5, 32'h0);
    repeat (2) @(negedge clock_i);
    chk("irq_clr", 1'b0, irq_o);
    wr(8'h44, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(8'h3C, 32'(4 | s));
      wdt_gap(n);
      chk("wdt_sel", CYC[s], n);
    end
    rd("status_wdt", 8'h40, 32'h2, 32'h2);
    wr(8'h3C, 32'h3);
    halt_i <= 1'b1;
    n = 0;
    repeat (200) begin @(negedge clock_i); n += int'(wdt_rst_o === 1'b1); end
    chk("wdt_halt_stop", 0, n);
    halt_i <= 1'b0;
    stop_wake(0, 1'b1, n, port);
    wdt_gap(n);
    chk("wdt_keep", 80, n);
    wr(8'h3C, 32'h4);
    n = 0;
    repeat (20) begin
      @(posedge clock_i);
      wdt_kick_i <= 1'b1;
      @(posedge clock_i);
      wdt_kick_i <= 1'b0;
      repeat (3) @(negedge clock_i);
      n += int'(wdt_rst_o === 1'b1);
    end
    chk("wdt_kick", 0, n);
    stop_test();
  end

  initial begin
    #400us;
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
